// file: inc/fp_mac_pkg.sv
// shared constants and types for the status-field and multiply-add unit
package fp_mac_pkg;
    localparam int REG_W = 82;
    localparam int SIG_W = 64;
    localparam int EXP_W = 17;
    localparam int CTL_W = 7;
    localparam int FLG_W = 6;
    localparam int FLD_W = CTL_W + FLG_W;
    localparam int NUM_SF = 4;
    localparam int SF_LSB = FLG_W;
    localparam int STAT_W = FLG_W + NUM_SF * FLD_W;
    localparam int FLG_LSB = CTL_W;
    localparam int TD_POS = 6;
    localparam int SIGN_POS = 81;
    localparam int EXP_MSB = 80;
    localparam int EXP_LSB = 64;
    localparam int QUIET_POS = 62;
    localparam logic [FLG_W-1:0] TRAPS_RST = 6'h3F;
    localparam logic [CTL_W-1:0] CTL_RST = 7'h00;
    localparam logic [EXP_W-1:0] EXP_INT = 17'h1003E;
    localparam logic [EXP_W-1:0] EXP_SPEC = 17'h1FFFE;
    localparam logic [EXP_W-1:0] EXP_MAX = 17'h1FFFF;
    localparam logic [EXP_W:0] RCP_EXP_K = 18'h1FFFE;
    localparam logic [EXP_W:0] RSQ_EXP_K = 18'h2FFFD;
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_CHKF = 4'h1,
        OP_CLRF = 4'h2,
        OP_SETC = 4'h3,
        OP_INT_MUL_ADD_LOW = 4'h4,
        OP_INT_MUL_ADD_HIGH = 4'h5,
        OP_INT_MUL_ADD_HIGH_UNSIGNED = 4'h6,
        OP_INT_MUL_ADD_LOW_UNSIGNED = 4'h7,
        OP_AND = 4'h8,
        OP_ANDCM = 4'h9,
        OP_OR = 4'hA,
        OP_XOR = 4'hB,
        OP_NAN_PICK = 4'hC,
        OP_RCPA = 4'hD,
        OP_RSQRTA = 4'hE
    } op_t;
endpackage : fp_mac_pkg

// file: src/fp_status_and_int_mac.sv
// floating-point status fields, integer multiply-add and significand ops
//
// Overview of operation
// RL1: non-arithmetic ops work at full 82-bit register width, no precision or field.
// RL2: speculative flags go to an alternate field; the primary stays untouched.
// RL3: check-flags faults when an alternate flag matches an enabled trap.
// RL4: check-flags faults when an alternate flag is clear in primary flags.
// RL5: otherwise check-flags changes nothing and completes as a no-op.
// RL6: set-controls writes (primary controls AND and-mask) OR or-mask.
// RL7: clear-flags zeroes the selected field's flags, controls kept.
// RL8: multiply two 64-bit significands, add zero-extended third, 128-bit sum.
// RL9: sign and exponent ignored except to spot the speculative-invalid token.
// RL10: low form writes low 64 bits, high form upper; canonical integer.
// RL11: signed forms treat sources signed, unsigned forms unsigned.
// RL12: NaN is signaling when top fraction bit is zero, quiet when one.
// RL13: NaN propagation priority is f4 operand, then f2, then f3.
// RL14: logical ops act bitwise on source significands.
// RL15: every operand precision mix is accepted without check.
// RL16: provide reciprocal and reciprocal-square-root approximations.
// RL17: trap-disable bit set makes all traps count as disabled.
// RL18: selector zero to three picks the controlling and recording field.
// RL19: unsigned-low shares the signed-low hardware.
// RL20: check-flags fault reported before any status field changes.
`timescale 1ns/1ns
module fp_status_and_int_mac #(
    parameter int SIG_W = 64
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic opValid,
    input wire fp_mac_pkg::op_t opCode,
    input wire logic [1:0] fieldSel,
    input wire logic [fp_mac_pkg::CTL_W-1:0] andMask,
    input wire logic [fp_mac_pkg::CTL_W-1:0] orMask,
    input wire logic [fp_mac_pkg::REG_W-1:0] srcF2,
    input wire logic [fp_mac_pkg::REG_W-1:0] srcF3,
    input wire logic [fp_mac_pkg::REG_W-1:0] srcF4,
    input wire logic flagValid,
    input wire logic flagSpec,
    input wire logic [1:0] flagField,
    input wire logic [fp_mac_pkg::FLG_W-1:0] flagBits,
    input wire logic trapsWe,
    input wire logic [fp_mac_pkg::FLG_W-1:0] trapsIn,
    output logic resultValid,
    output logic [fp_mac_pkg::REG_W-1:0] result,
    output logic specFault,
    output logic nanSignaling,
    output logic [fp_mac_pkg::STAT_W-1:0] fp_status_reg
);
    import fp_mac_pkg::*;

    logic [CTL_W-1:0] ctl [NUM_SF];
    logic [FLG_W-1:0] flg [NUM_SF];
    logic [FLG_W-1:0] traps;
    logic [SIG_W-1:0] macOut;
    logic macSigned;
    logic macHigh;
    logic natIn;
    logic chkTrap;
    logic chkNew;
    logic [1:0] flagDest;
    logic [FLG_W-1:0] altFlags;
    logic [CTL_W-1:0] setcValue;
    logic [REG_W-1:0] next_result;
    logic next_fault;
    logic next_snan;
    logic [EXP_W:0] rcpExp;
    logic [EXP_W:0] rsqExp;
    logic [EXP_W:0] rsqDiff;

    if (SIG_W != 64) begin : g_bad_width
        $error("fp_status_and_int_mac: register layout needs SIG_W of 64");
    end

    // ---------------- helpers ----------------

    function automatic logic isNat(input logic [REG_W-1:0] r);
        return !r[SIGN_POS] && r[EXP_MSB:EXP_LSB] == EXP_SPEC && r[SIG_W-1:0] == '0;
    endfunction : isNat

    function automatic logic isNan(input logic [REG_W-1:0] r);
        return r[EXP_MSB:EXP_LSB] == EXP_MAX && r[QUIET_POS:0] != '0;
    endfunction : isNan

    // RL12 signaling test
    function automatic logic isSignaling(input logic [REG_W-1:0] r);
        return isNan(r) && !r[QUIET_POS];
    endfunction : isSignaling

    function automatic logic [REG_W-1:0] canonInt(input logic [SIG_W-1:0] s);
        return {1'b0, EXP_INT, s};
    endfunction : canonInt

    // RL2 speculative redirect
    function automatic logic [1:0] destField(input logic spec, input logic [1:0] sel);
        return (spec && sel == 2'h0) ? 2'h1 : sel;
    endfunction : destField

    // RL17 effective enables
    function automatic logic [FLG_W-1:0] enabledTraps(input logic td, input logic [FLG_W-1:0] t);
        return td ? '0 : ~t;
    endfunction : enabledTraps

    // ---------------- check and set decode ----------------

    // RL18 field select
    assign altFlags = flg[fieldSel];
    assign flagDest = destField(flagSpec, flagField);
    // RL3 enabled-trap match
    assign chkTrap = |(altFlags & enabledTraps(ctl[fieldSel][TD_POS], traps));
    // RL4 unregistered event
    assign chkNew = |(altFlags & ~flg[0]);
    // RL6 control merge
    assign setcValue = (ctl[0] & andMask) | orMask;

    // ---------------- multiply-add ----------------

    // RL19 shared low half
    assign macSigned = opCode == OP_INT_MUL_ADD_LOW || opCode == OP_INT_MUL_ADD_HIGH
        || opCode == OP_INT_MUL_ADD_LOW_UNSIGNED;
    assign macHigh = opCode == OP_INT_MUL_ADD_HIGH || opCode == OP_INT_MUL_ADD_HIGH_UNSIGNED;
    // RL9 token check only
    assign natIn = isNat(srcF2) || isNat(srcF3) || isNat(srcF4);

    int_mul_add #(
        .SIG_W(SIG_W)
    ) u_mac (
        .mulA(srcF3[SIG_W-1:0]),
        .mulB(srcF4[SIG_W-1:0]),
        .addC(srcF2[SIG_W-1:0]),
        .signedMode(macSigned),
        .highHalf(macHigh),
        .product(macOut)
    );

    // coarse seeds only; special operands are not screened
    assign rcpExp = RCP_EXP_K - {1'b0, srcF3[EXP_MSB:EXP_LSB]}
        - {{EXP_W{1'b0}}, srcF3[QUIET_POS:0] != '0};
    assign rsqDiff = RSQ_EXP_K - {1'b0, srcF3[EXP_MSB:EXP_LSB]};
    assign rsqExp = rsqDiff >> 1;

    // ---------------- result forming ----------------

    // RL1 full-width results
    always_comb begin
        next_result = '0;
        next_fault = 1'b0;
        next_snan = 1'b0;
        case (opCode)
            // RL5 no state written
            // RL20 fault before change
            OP_CHKF: begin
                next_fault = chkTrap || chkNew;
            end
            OP_INT_MUL_ADD_LOW, OP_INT_MUL_ADD_HIGH,
            OP_INT_MUL_ADD_HIGH_UNSIGNED, OP_INT_MUL_ADD_LOW_UNSIGNED: begin
                next_result = natIn ? {1'b0, EXP_SPEC, {SIG_W{1'b0}}} : canonInt(macOut);
            end
            // RL14 bitwise significand
            OP_AND: begin
                next_result = canonInt(srcF2[SIG_W-1:0] & srcF3[SIG_W-1:0]);
            end
            OP_ANDCM: begin
                next_result = canonInt(srcF2[SIG_W-1:0] & ~srcF3[SIG_W-1:0]);
            end
            OP_OR: begin
                next_result = canonInt(srcF2[SIG_W-1:0] | srcF3[SIG_W-1:0]);
            end
            OP_XOR: begin
                next_result = canonInt(srcF2[SIG_W-1:0] ^ srcF3[SIG_W-1:0]);
            end
            // RL13 priority pick
            OP_NAN_PICK: begin
                if (isNan(srcF4)) begin
                    next_result = srcF4;
                    next_snan = isSignaling(srcF4);
                end else if (isNan(srcF2)) begin
                    next_result = srcF2;
                    next_snan = isSignaling(srcF2);
                end else if (isNan(srcF3)) begin
                    next_result = srcF3;
                    next_snan = isSignaling(srcF3);
                end
                next_result[QUIET_POS] = next_result[QUIET_POS] | next_snan;
            end
            // RL16 reciprocal seed
            OP_RCPA: begin
                next_result = {srcF3[SIGN_POS], rcpExp[EXP_W-1:0], 1'b1,
                    (srcF3[QUIET_POS:0] != '0) ? ~srcF3[QUIET_POS:0] : srcF3[QUIET_POS:0]};
            end
            OP_RSQRTA: begin
                next_result = {1'b0, rsqExp[EXP_W-1:0], 1'b1, 1'b0, ~srcF3[QUIET_POS:1]};
            end
            default: begin
                next_result = '0;
            end
        endcase
    end

    // RL15 no precision gate
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            resultValid <= 1'b0;
            result <= '0;
            specFault <= 1'b0;
            nanSignaling <= 1'b0;
        end else begin
            resultValid <= opValid && opCode != OP_NONE;
            specFault <= opValid && next_fault;
            if (opValid) begin
                result <= next_result;
                nanSignaling <= next_snan;
            end
        end
    end

    // ---------------- status fields ----------------

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            traps <= TRAPS_RST;
        end else if (trapsWe) begin
            traps <= trapsIn;
        end
    end

    for (genvar k = 0; k < NUM_SF; k++) begin : g_field
        logic selHit;
        logic evtHit;
        assign selHit = opValid && fieldSel == 2'(k);
        assign evtHit = flagValid && flagDest == 2'(k);

        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                ctl[k] <= CTL_RST;
            end else if (selHit && opCode == OP_SETC) begin
                // primary trap-disable is reserved and stays zero
                ctl[k] <= (k == 0) ? (setcValue & ~(CTL_W'(1) << TD_POS)) : setcValue;
            end
        end

        // RL7 clear, event wins
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                flg[k] <= '0;
            end else if (selHit && opCode == OP_CLRF) begin
                flg[k] <= evtHit ? flagBits : '0;
            end else if (evtHit) begin
                flg[k] <= flg[k] | flagBits;
            end
        end

        assign fp_status_reg[SF_LSB + k*FLD_W +: FLD_W] = {flg[k], ctl[k]};
    end
    assign fp_status_reg[FLG_W-1:0] = traps;

    // ---------------- assertions ----------------

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence s_chk;
        opValid && opCode == OP_CHKF;
    endsequence

    sequence s_quiet_bus;
        !flagValid && !trapsWe;
    endsequence

    property p_chk_trap;
        s_chk and chkTrap |=> specFault;
    endproperty
    a_chk_trap: assert property (p_chk_trap) else $error("enabled trap flag did not fault"); // RL3

    property p_chk_new;
        s_chk and (|(flg[fieldSel] & ~flg[0])) |=> specFault && resultValid;
    endproperty
    a_chk_new: assert property (p_chk_new) else $error("unregistered flag did not fault"); // RL4

    property p_chk_noop;
        s_chk and s_quiet_bus and !chkTrap and !chkNew |=> !specFault && $stable(fp_status_reg);
    endproperty
    a_chk_noop: assert property (p_chk_noop) else $error("clean check changed state"); // RL5

    property p_fault_first;
        s_chk and s_quiet_bus |=> $stable(fp_status_reg);
    endproperty
    a_fault_first: assert property (p_fault_first) else $error("check altered a field"); // RL20

    property p_setc;
        opValid && opCode == OP_SETC && fieldSel == 2'h2 |=> ctl[2] == $past(setcValue);
    endproperty
    a_setc: assert property (p_setc) else $error("controls not merged from masks"); // RL6

    property p_clrf;
        opValid && opCode == OP_CLRF && fieldSel == 2'h3 && !flagValid
            |=> flg[3] == '0 && $stable(ctl[3]);
    endproperty
    a_clrf: assert property (p_clrf) else $error("clear left flags or hit controls"); // RL7

    // only events aimed at field 0 or 1 land in field 1
    property p_spec;
        flagValid && flagSpec && !flagField[1] && !(opValid && opCode == OP_CLRF)
            |=> flg[1] == ($past(flg[1]) | $past(flagBits)) && $stable(flg[0]);
    endproperty
    a_spec: assert property (p_spec) else $error("speculative flags reached primary"); // RL2

    property p_mac_low;
        opValid && opCode == OP_INT_MUL_ADD_LOW_UNSIGNED && !natIn
            |=> result == canonInt($past(srcF3[SIG_W-1:0] * srcF4[SIG_W-1:0] + srcF2[SIG_W-1:0]));
    endproperty
    a_mac_low: assert property (p_mac_low) else $error("low multiply-add wrong"); // RL10

    property p_nat;
        opValid && macSigned && natIn ##1 resultValid |-> result[EXP_MSB:EXP_LSB] == EXP_SPEC;
    endproperty
    a_nat: assert property (p_nat) else $error("token operand not propagated"); // RL9

    property p_nan_pri;
        opValid && opCode == OP_NAN_PICK && isNan(srcF4)
            |=> result[QUIET_POS-1:0] == $past(srcF4[QUIET_POS-1:0]) && result[QUIET_POS]
                && nanSignaling == !$past(srcF4[QUIET_POS]);
    endproperty
    a_nan_pri: assert property (p_nan_pri) else $error("f4 NaN not chosen first"); // RL13

    property p_xor;
        opValid && opCode == OP_XOR |=> result[SIG_W-1:0] == $past(srcF2[SIG_W-1:0] ^ srcF3[SIG_W-1:0]);
    endproperty
    a_xor: assert property (p_xor) else $error("xor of significands wrong"); // RL14

    property p_nan_f2;
        opValid && opCode == OP_NAN_PICK && !isNan(srcF4) && isNan(srcF2)
            |=> result[QUIET_POS-1:0] == $past(srcF2[QUIET_POS-1:0]) && result[QUIET_POS];
    endproperty
    a_nan_f2: assert property (p_nan_f2) else $error("f2 NaN not chosen second"); // RL13

    property p_idle_quiet;
        !opValid |=> !resultValid && !specFault;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("result pulse without a taken op"); // RL5

    // td set hides every trap, so only a new flag may fault
    property p_td_masks;
        s_chk and (ctl[fieldSel][TD_POS] && !chkNew) |=> !specFault;
    endproperty
    a_td_masks: assert property (p_td_masks) else $error("trap-disable did not mask traps"); // RL17

endmodule : fp_status_and_int_mac

// file: src/int_mul_add.sv
// combinational 64x64 multiply plus zero-extended addend, half select
`timescale 1ns/1ns
module int_mul_add #(
    parameter int SIG_W = 64
) (
    input wire logic [SIG_W-1:0] mulA,
    input wire logic [SIG_W-1:0] mulB,
    input wire logic [SIG_W-1:0] addC,
    input wire logic signedMode,
    input wire logic highHalf,
    output logic [SIG_W-1:0] product
);
    logic [2*SIG_W-1:0] extA;
    logic [2*SIG_W-1:0] extB;
    logic [2*SIG_W-1:0] sum;

    if (SIG_W < 2) begin : g_bad_width
        $error("int_mul_add: SIG_W must be at least 2");
    end

    // RL11 sign interpretation
    assign extA = signedMode ? {{SIG_W{mulA[SIG_W-1]}}, mulA} : {{SIG_W{1'b0}}, mulA};
    assign extB = signedMode ? {{SIG_W{mulB[SIG_W-1]}}, mulB} : {{SIG_W{1'b0}}, mulB};
    // RL8 double-width sum
    assign sum = extA * extB + {{SIG_W{1'b0}}, addC};
    // RL10 half select
    assign product = highHalf ? sum[2*SIG_W-1:SIG_W] : sum[SIG_W-1:0];
endmodule : int_mul_add

// file: test/fp_flag_source.sv
// pipeline-side model that reports arithmetic flag events to the unit
`timescale 1ns/1ns
module fp_flag_source (
    input wire logic mclk,
    output logic flagValid,
    output logic flagSpec,
    output logic [1:0] flagField,
    output logic [5:0] flagBits
);
    initial begin
        flagValid = 1'b0;
        flagSpec = 1'b0;
        flagField = 2'h0;
        flagBits = 6'h00;
    end

    // random gap of at least one edge, so back-to-back posts never re-raise valid at once
    task automatic post(input logic s, input logic [1:0] f, input logic [5:0] b);
        repeat (1 + $urandom_range(3)) @(negedge mclk);
        flagValid = 1'b1;
        flagSpec = s;
        flagField = f;
        flagBits = b;
        @(negedge mclk);
        flagValid = 1'b0;
        // idle bits and field lines must not keep showing the last event; flagSpec keeps its value
        flagBits = ~b;
        flagField = ~f;
    endtask : post
endmodule : fp_flag_source

// file: test/fp_status_and_int_mac_tb.sv
// self-checking bench for the status-field and multiply-add unit
`timescale 1ns/1ns
module fp_status_and_int_mac_tb;
    import fp_mac_pkg::*;
    logic mclk, arst_n, opValid, trapsWe, flagValid, flagSpec;
    op_t opCode;
    logic [1:0] fieldSel, flagField;
    logic [6:0] andMask, orMask;
    logic [81:0] srcF2, srcF3, srcF4, result;
    logic [5:0] flagBits, trapsIn;
    logic resultValid, specFault, nanSignaling;
    logic [STAT_W-1:0] fp_status_reg;
    logic [85:0] expQ[$];
    logic [85:0] expE;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;

    fp_status_and_int_mac #(.SIG_W(64)) dut (.mclk(mclk), .arst_n(arst_n), .opValid(opValid),
        .opCode(opCode), .fieldSel(fieldSel), .andMask(andMask), .orMask(orMask), .srcF2(srcF2),
        .srcF3(srcF3), .srcF4(srcF4), .flagValid(flagValid), .flagSpec(flagSpec), .flagField(flagField),
        .flagBits(flagBits), .trapsWe(trapsWe), .trapsIn(trapsIn), .resultValid(resultValid),
        .result(result), .specFault(specFault), .nanSignaling(nanSignaling), .fp_status_reg(fp_status_reg));
    fp_flag_source src (.mclk(mclk), .flagValid(flagValid), .flagSpec(flagSpec), .flagField(flagField),
        .flagBits(flagBits));

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    function automatic logic [85:0] ev(input logic cr, cn, n, f, input logic [81:0] r);
        return {cr, cn, n, f, r};
    endfunction : ev

    function automatic logic [81:0] intv(input logic [63:0] s);
        return {1'b0, EXP_INT, s};
    endfunction : intv

    function automatic logic [81:0] rnd82;
        return 82'({$urandom(), $urandom(), $urandom()});
    endfunction : rnd82

    function automatic logic [12:0] fld(input int k);
        return fp_status_reg[SF_LSB + FLD_W * k +: FLD_W];
    endfunction : fld

    // op stays presented so calls run back to back
    task automatic issue(input op_t op, input logic [81:0] a, b, c, input logic [1:0] fs,
                         input logic [85:0] e);
        opValid = 1'b1;
        opCode = op;
        srcF2 = a;
        srcF3 = b;
        srcF4 = c;
        fieldSel = fs;
        expQ.push_back(e);
        @(negedge mclk);
    endtask : issue

    task automatic idle;
        opValid = 1'b0;
        opCode = OP_NONE;
        srcF2 = ~srcF2;
        @(negedge mclk);
    endtask : idle

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            final_report();
        end
    end

    // each result pulse consumes the oldest expectation
    always @(negedge mclk) begin
        if (resultValid === 1'b1) begin
            if (expQ.size() == 0) begin
                chk(1, 0);
            end else begin
                expE = expQ.pop_front();
                if (expE[85]) chk(result, expE[81:0]);
                chk(specFault, expE[82]);
                if (expE[84]) chk(nanSignaling, expE[83]);
            end
        end
    end

    initial begin
        logic [81:0] a, b, c, num;
        logic [127:0] p;
        logic [63:0] r;
        logic [3:0] k;
        arst_n = 1'b0;
        opValid = 1'b0;
        opCode = OP_NONE;
        fieldSel = 2'h0;
        andMask = 7'h00;
        orMask = 7'h00;
        srcF2 = '0;
        srcF3 = '0;
        srcF4 = '0;
        trapsWe = 1'b0;
        trapsIn = 6'h00;
        void'($urandom(59052));
        repeat (3) @(negedge mclk);
        arst_n = 1'b1;
        chk(fp_status_reg, STAT_W'(TRAPS_RST));
        for (int i = 0; i < 16; i++) begin
            a = rnd82();
            b = rnd82();
            k = 4'(8 + i % 4);
            case (i % 4)
                0: r = a[63:0] & b[63:0];
                1: r = a[63:0] & ~b[63:0];
                2: r = a[63:0] | b[63:0];
                default: r = a[63:0] ^ b[63:0];
            endcase
            issue(op_t'(k), a, b, a, 2'h0, ev(1, 0, 0, 0, intv(r)));
        end
        for (int i = 0; i < 16; i++) begin
            a = rnd82();
            b = rnd82();
            c = rnd82();
            k = 4'(4 + i % 4);
            if (k < 6) p = {{64{b[63]}}, b[63:0]} * {{64{c[63]}}, c[63:0]};
            else p = {64'h0, b[63:0]} * {64'h0, c[63:0]};
            p = p + {64'h0, a[63:0]};
            r = (k == 5 || k == 6) ? p[127:64] : p[63:0];
            issue(op_t'(k), a, b, c, 2'h0, ev(1, 0, 0, 0, intv(r)));
        end
        idle();
        a = {1'b0, EXP_SPEC, 64'h0};
        issue(OP_INT_MUL_ADD_LOW, rnd82(), a, rnd82(), 2'h0, ev(1, 0, 0, 0, a));
        num = intv(64'h5);
        a = {1'b0, EXP_MAX, 2'b10, 62'h1234};
        b = {1'b1, EXP_MAX, 2'b11, 62'h77};
        issue(OP_NAN_PICK, b, a, a, 2'h0, ev(1, 1, 1, 0, a | 82'h1 << QUIET_POS));
        issue(OP_NAN_PICK, b, a, num, 2'h0, ev(1, 1, 0, 0, b));
        issue(OP_NAN_PICK, num, a, num, 2'h0, ev(1, 1, 1, 0, a | 82'h1 << QUIET_POS));
        issue(OP_RCPA, num, num, num, 2'h0, ev(1, 0, 0, 0, {1'b0, 17'h0FFBF, 64'hFFFF_FFFF_FFFF_FFFA}));
        issue(OP_RSQRTA, num, num, num, 2'h0, ev(1, 0, 0, 0, {1'b0, 17'h0FFDF, 64'hBFFF_FFFF_FFFF_FFFD}));
        idle();
        src.post(1'b0, 2'h0, 6'h01);
        src.post(1'b1, 2'h2, 6'h03);
        src.post(1'b1, 2'h0, 6'h04);
        chk(fld(0), 13'h0080);
        chk(fld(1), 13'h0200);
        issue(OP_CHKF, num, num, num, 2'h2, ev(0, 0, 0, 1, num));
        idle();
        chk(fld(2), 13'h0180);
        chk(fld(0), 13'h0080);
        src.post(1'b1, 2'h3, 6'h01);
        issue(OP_CHKF, num, num, num, 2'h3, ev(0, 0, 0, 0, num));
        idle();
        trapsWe = 1'b1;
        trapsIn = 6'h3E;
        @(negedge mclk);
        trapsWe = 1'b0;
        issue(OP_CHKF, num, num, num, 2'h3, ev(0, 0, 0, 1, num));
        andMask = 7'h7F;
        orMask = 7'h0A;
        issue(OP_SETC, num, num, num, 2'h0, ev(0, 0, 0, 0, num));
        orMask = 7'h40;
        issue(OP_SETC, num, num, num, 2'h3, ev(0, 0, 0, 0, num));
        orMask = 7'h10;
        issue(OP_SETC, num, num, num, 2'h2, ev(0, 0, 0, 0, num));
        idle();
        chk(fld(3), 13'h00CA);
        chk(fld(2), 13'h019A);
        issue(OP_CHKF, num, num, num, 2'h3, ev(0, 0, 0, 0, num));
        issue(OP_CLRF, num, num, num, 2'h2, ev(0, 0, 0, 0, num));
        idle();
        chk(fld(2), 13'h001A);
        repeat (3) idle();
        chk(expQ.size(), 0);
        final_report();
    end
endmodule : fp_status_and_int_mac_tb
